// ==== logic/tmr3_pkg.sv ====
package tmr3_pkg;
    // Register map (index into the plain register port)
    localparam logic [3:0] TMR3_CTRL_OFS = 4'h0;
    localparam logic [3:0] TMR3_COUNT_OFS = 4'h1;
    localparam logic [3:0] TMR3_STAT_OFS = 4'h2;
    // Control field positions
    localparam int TMR3_RUN_BIT = 15;
    localparam int TMR3_IDLE_BIT = 13;
    localparam int TMR3_GATE_BIT = 6;
    localparam int TMR3_PS_HI = 5;
    localparam int TMR3_PS_LO = 4;
    localparam int TMR3_CS_BIT = 1;
    // Writable bits of the control register
    localparam logic [15:0] TMR3_CTRL_MASK = 16'hA072;
    localparam logic [15:0] TMR3_CTRL_RST = 16'h0000;
    localparam logic [15:0] TMR3_COUNT_RST = 16'h0000;
    localparam logic [7:0] TMR3_PS_RST = 8'h00;
    // Prescale codes
    localparam logic [1:0] TMR3_PS_1 = 2'h0;
    localparam logic [1:0] TMR3_PS_8 = 2'h1;
    localparam logic [1:0] TMR3_PS_64 = 2'h2;
    localparam logic [1:0] TMR3_PS_256 = 2'h3;
    // Prescaler terminal counts (ratio minus one)
    localparam logic [7:0] TMR3_TC_1 = 8'h00;
    localparam logic [7:0] TMR3_TC_8 = 8'h07;
    localparam logic [7:0] TMR3_TC_64 = 8'h3F;
    localparam logic [7:0] TMR3_TC_256 = 8'hFF;
    localparam logic [2:0] TMR3_SYNC_RST = 3'h0;

    // Terminal count for a prescale code
    function automatic logic [7:0] tmr3_term_count(input logic [1:0] code);
        case (code)
            TMR3_PS_8: tmr3_term_count = TMR3_TC_8;
            TMR3_PS_64: tmr3_term_count = TMR3_TC_64;
            TMR3_PS_256: tmr3_term_count = TMR3_TC_256;
            default: tmr3_term_count = TMR3_TC_1;
        endcase
    endfunction
endpackage

// ==== logic/tmr3_pin_sync.sv ====
`timescale 1ns/100ps
// Three-stage synchroniser with rising edge detect on agreed stages
module tmr3_pin_sync
    import tmr3_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Asynchronous pin
    input wire logic pin_i,
    // Synchronised level and its rising edge
    output logic level_o,
    output logic rise_o
);
    logic [2:0] sync_ff;
    logic [2:0] nxt_sync;
    logic level_ff;
    logic nxt_level;

    // Level changes only when stages two and three agree; stage one feeds stage two only
    always_comb begin
        nxt_sync = {sync_ff[1:0], pin_i};
        nxt_level = level_ff;
        if (sync_ff[1] == sync_ff[2]) begin
            nxt_level = sync_ff[2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync_ff <= TMR3_SYNC_RST;
            level_ff <= 1'b0;
        end else begin
            sync_ff <= nxt_sync;
            level_ff <= nxt_level;
        end
    end

    assign level_o = level_ff;
    assign rise_o = nxt_level & ~level_ff;
endmodule

// ==== logic/tmr3_core.sv ====
`timescale 1ns/100ps
// Summary of operation
// - External clock selected: gate-accumulate bit has no effect on counting.
// - Internal clock, gate bit set: count only while the gate input is active.
// - Internal clock, gate bit clear: count prescaled clock continuously.
// - Prescale code 11 divides by 256, 10 by 64, 01 by 8, 00 by 1.
// - Partner cascade mode on: gate, prescale and clock source controls do nothing.
module tmr3_core
    import tmr3_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Timer inputs
    input wire logic cy_tick_i,
    input wire logic timer_three_ext_clock_pin_i,
    input wire logic gate_pin_i,
    input wire logic cascade_32bit_mode_i,
    input wire logic cpu_idle_i,
    // Timer outputs
    output logic [15:0] count_o,
    output logic count_tick_o,
    output logic timer_running_o
);
    // Run states; HALT keeps count and prescaler but lets no tick through
    typedef enum logic [1:0] {
        TMR3_ST_STOP,
        TMR3_ST_RUN,
        TMR3_ST_HALT
    } tmr3_state_t;

    // Control register and its fields
    logic [15:0] timer_three_control_ff;
    logic [15:0] nxt_ctrl;
    logic timer_run_enable;
    logic halt_in_idle;
    logic gate_accumulate_enable;
    logic [1:0] input_prescale_select;
    logic clock_source_select;

    // Run state and the running flag
    tmr3_state_t state_ff;
    tmr3_state_t nxt_state;
    logic halt_req;
    logic run_ff;
    logic nxt_run;

    // Prescaler
    logic [7:0] ps_ff;
    logic [7:0] nxt_ps;
    logic [7:0] ps_term;
    logic ps_wrap;

    // Counter and increment pulse
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic tick_ff;
    logic nxt_tick;
    logic count_step;

    // Register port decode and read path
    logic ctrl_wr;
    logic count_wr;
    logic [15:0] status_word;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;

    // Synchronised gate level and external edge pulse
    logic gate_level;
    logic ext_rise;

    // Selected source and gate
    logic src_tick;
    logic gate_ok;
    logic adv;

    // True when a strobe addresses the given register index
    // Kept as a function so both register write decodes read the same way
    function automatic logic tmr3_hit(
        input logic strobe,
        input logic [3:0] addr,
        input logic [3:0] ofs
    );
        tmr3_hit = strobe && (addr == ofs);
    endfunction

    // Pin synchronisers: gate and external clock come from outside this domain
    // Both pins pass three flops; a change counts once stages two and three agree
    tmr3_pin_sync u_gate_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(gate_pin_i),
        .level_o(gate_level),
        .rise_o()
    );

    // Only the rising edge matters for the external source; its level is unused
    tmr3_pin_sync u_ext_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(timer_three_ext_clock_pin_i),
        .level_o(),
        .rise_o(ext_rise)
    );

    // Control field extraction
    assign timer_run_enable = timer_three_control_ff[TMR3_RUN_BIT];
    assign halt_in_idle = timer_three_control_ff[TMR3_IDLE_BIT];
    assign gate_accumulate_enable = timer_three_control_ff[TMR3_GATE_BIT];
    assign input_prescale_select = timer_three_control_ff[TMR3_PS_HI:TMR3_PS_LO];
    assign clock_source_select = timer_three_control_ff[TMR3_CS_BIT];

    // Register port write decode; the read strobe is decoded in the read path
    assign ctrl_wr = tmr3_hit(reg_wr_i, reg_addr_i, TMR3_CTRL_OFS);
    assign count_wr = tmr3_hit(reg_wr_i, reg_addr_i, TMR3_COUNT_OFS);

    // Source and gate selection
    // External edges are already one-cycle pulses, the same shape as cy_tick_i
    // The gate level trails its pin by about four cycles through the synchroniser
    always_comb begin
        src_tick = clock_source_select ? ext_rise : cy_tick_i;
        gate_ok = clock_source_select | ~gate_accumulate_enable | gate_level;
        // cascade disables controls
        // The partner owns this timer in cascade mode, so nothing here may count
        if (cascade_32bit_mode_i) begin
            src_tick = 1'b0;
            gate_ok = 1'b0;
        end
    end

    // Idle halt applies only while its control bit is set
    assign halt_req = halt_in_idle && cpu_idle_i;

    // Run state: the run bit overrides everything, idle only pauses
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TMR3_ST_STOP: begin
                // The prescaler is held cleared for as long as this state lasts
                if (timer_run_enable) begin
                    nxt_state = TMR3_ST_RUN;
                end
            end
            TMR3_ST_RUN: begin
                // A stop write wins over an idle request
                if (!timer_run_enable) begin
                    nxt_state = TMR3_ST_STOP;
                end else if (halt_req) begin
                    nxt_state = TMR3_ST_HALT;
                end
            end
            TMR3_ST_HALT: begin
                // Leaving HALT resumes without restarting the prescaler
                if (!timer_run_enable) begin
                    nxt_state = TMR3_ST_STOP;
                end else if (!halt_req) begin
                    nxt_state = TMR3_ST_RUN;
                end
            end
            default: nxt_state = TMR3_ST_STOP;
        endcase
    end

    // Run state register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_ff <= TMR3_ST_STOP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Running flag follows the next state so the pin lines up with state_ff
    always_comb begin
        nxt_run = (nxt_state == TMR3_ST_RUN);
    end

    // Running flag register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_ff <= 1'b0;
        end else begin
            run_ff <= nxt_run;
        end
    end

    // advance only while running
    // The run bit is tested too, so a stop write holds before the state catches up
    assign adv = (state_ff == TMR3_ST_RUN) && timer_run_enable && src_tick && gate_ok;

    // prescale divide
    // Terminal count is the ratio minus one, so code 00 wraps on every tick
    assign ps_term = tmr3_term_count(input_prescale_select);
    // Greater-or-equal: a code lowered mid-count wraps at once instead of running past
    assign ps_wrap = (ps_ff >= ps_term);
    assign count_step = adv && ps_wrap;

    // Prescaler; restarts when the timer stops but not on a code change
    always_comb begin
        nxt_ps = ps_ff;
        if (state_ff == TMR3_ST_STOP) begin
            nxt_ps = TMR3_PS_RST;
        end else if (count_step) begin
            nxt_ps = TMR3_PS_RST;
        end else if (adv) begin
            nxt_ps = ps_ff + 8'h01;
        end
    end

    // Prescaler register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ps_ff <= TMR3_PS_RST;
        end else begin
            ps_ff <= nxt_ps;
        end
    end

    // Counter; a software write wins over an increment in the same cycle
    // The count simply wraps after all ones; no period match is done here
    always_comb begin
        nxt_count = count_ff;
        nxt_tick = 1'b0;
        if (count_step) begin
            nxt_count = count_ff + 16'h0001;
            nxt_tick = 1'b1;
        end
        if (count_wr) begin
            nxt_count = reg_wdata_i;
        end
    end

    // Counter and increment pulse registers
    // The pulse marks the cycle in which the new count first shows
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count_ff <= TMR3_COUNT_RST;
            tick_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tick_ff <= nxt_tick;
        end
    end

    // Control write; unimplemented bits are never stored, so they read back as zero
    // A run bit change reaches the state machine one cycle later
    always_comb begin
        nxt_ctrl = timer_three_control_ff;
        if (ctrl_wr) begin
            nxt_ctrl = reg_wdata_i & TMR3_CTRL_MASK;
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            timer_three_control_ff <= TMR3_CTRL_RST;
        end else begin
            timer_three_control_ff <= nxt_ctrl;
        end
    end

    // Status word: state in the low bits, synchronised gate level above
    // Bit two lets software see the gate without probing the pin
    assign status_word = {13'h0000, gate_level, state_ff};

    // Read mux; idle cycles return zero so a stale word is never taken for data
    // Unmapped indices read as zero, and their writes are dropped in the decode above
    always_comb begin
        nxt_rdata = 16'h0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                TMR3_CTRL_OFS: nxt_rdata = timer_three_control_ff;
                TMR3_COUNT_OFS: nxt_rdata = count_ff;
                TMR3_STAT_OFS: nxt_rdata = status_word;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs straight from their flip-flops, no logic in between
    assign reg_rdata_o = rdata_ff;
    assign count_o = count_ff;
    assign count_tick_o = tick_ff;
    assign timer_running_o = run_ff;
endmodule

// ==== verification/tmr3_core_checker.sv ====
`timescale 1ns/100ps
// Port-level checks on the timer three core
module tmr3_core_checker
    import tmr3_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // Timer side
    input wire logic cy_tick_i,
    input wire logic cascade_32bit_mode_i,
    input wire logic [15:0] count_o,
    input wire logic count_tick_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // Control written and then left alone for a cycle
    sequence s_run_plain;
        reg_wr_i && reg_addr_i == TMR3_CTRL_OFS && reg_wdata_i == 16'h8000 ##1 !reg_wr_i;
    endsequence
    sequence s_stop;
        reg_wr_i && reg_addr_i == TMR3_CTRL_OFS && !reg_wdata_i[15] ##1 !reg_wr_i;
    endsequence
    a_div_one_step: assert property (s_run_plain ##1 (cy_tick_i && !reg_wr_i && !cascade_32bit_mode_i)
        |=> count_o == $past(count_o) + 16'h0001) else $error("count missed a 1:1 tick");
    a_stop_holds: assert property (s_stop |=> $stable(count_o)) else $error("count moved while stopped");
    a_cascade_freeze: assert property ($past(cascade_32bit_mode_i) && !$past(reg_wr_i)
        |-> $stable(count_o)) else $error("count moved in cascade");
    a_tick_follows: assert property (count_o == $past(count_o) + 16'h0001 && !$past(reg_wr_i)
        |-> count_tick_o) else $error("no tick with increment");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data not idle");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > TMR3_STAT_OFS |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_ctrl_mask: assert property (reg_rd_i && reg_addr_i == TMR3_CTRL_OFS
        |=> (reg_rdata_o & ~TMR3_CTRL_MASK) == 16'h0000) else $error("unimplemented ctrl bit set");
endmodule
bind tmr3_core tmr3_core_checker u_chk(.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .cy_tick_i(cy_tick_i), .cascade_32bit_mode_i(cascade_32bit_mode_i), .count_o(count_o),
    .count_tick_o(count_tick_o));

// ==== verification/tmr3_core_tb.sv ====
`timescale 1ns/100ps
// Register-driven bench for the timer three core
module tmr3_core_tb import tmr3_pkg::*;;
    logic clk_i = 1'b0, srst_i = 1'b1, wr = 1'b0, rd = 1'b0, tk = 1'b0, ext = 1'b0, gate = 1'b0, casc = 1'b0;
    logic idle = 1'b0, run;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, cnt;
    int n_fail = 0, checks_done = 0, cyc = 0;
    int ratio [4] = '{1, 8, 64, 256};
    // Increment pulse is watched by the checker; the running flag is compared here
    tmr3_core u_dut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .cy_tick_i(tk), .timer_three_ext_clock_pin_i(ext),
        .gate_pin_i(gate), .cascade_32bit_mode_i(casc), .cpu_idle_i(idle), .count_o(cnt),
        .count_tick_o(), .timer_running_o(run));
    initial forever #2 clk_i = ~clk_i;
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", name, exp, got);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i) {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk_i) wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [3:0] a, input logic [15:0] exp, input string name);
        @(posedge clk_i) {rd, addr} <= {1'b1, a};
        @(posedge clk_i) rd <= 1'b0;
        #1 chk(name, exp, rdata);
    endtask
    // Spare cycle between pulses keeps each tick a clean single pulse
    task tick(input int n);
        repeat (n) begin
            @(posedge clk_i) tk <= 1'b1;
            @(posedge clk_i) tk <= 1'b0;
        end
    endtask
    task close_out;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard, far above the eight hundred or so cycles the run needs
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        rd_reg(TMR3_CTRL_OFS, 16'h0000, "ctrl reset");
        wr_reg(TMR3_CTRL_OFS, 16'hFFFF);
        rd_reg(TMR3_CTRL_OFS, 16'hA072, "ctrl mask");
        wr_reg(4'hF, 16'hFFFF);
        rd_reg(4'hF, 16'h0000, "unmapped");
        $display("registers done");
        for (int c = 0; c < 4; c++) begin
            wr_reg(TMR3_CTRL_OFS, 16'h0000);
            wr_reg(TMR3_COUNT_OFS, 16'h0000);
            wr_reg(TMR3_CTRL_OFS, 16'h8000 | (16'(c) << 4));
            tick(ratio[c] - 1);
            rd_reg(TMR3_COUNT_OFS, 16'h0000, "one short");
            tick(1);
            rd_reg(TMR3_COUNT_OFS, 16'h0001, "full ratio");
        end
        $display("prescale done");
        wr_reg(TMR3_CTRL_OFS, 16'h8040);
        tick(3);
        rd_reg(TMR3_COUNT_OFS, 16'h0001, "gate low");
        @(posedge clk_i) gate <= 1'b1;
        repeat (6) @(posedge clk_i);
        tick(3);
        rd_reg(TMR3_COUNT_OFS, 16'h0004, "gate high");
        rd_reg(TMR3_STAT_OFS, 16'h0005, "status gate run");
        @(posedge clk_i) gate <= 1'b0;
        wr_reg(TMR3_CTRL_OFS, 16'h8042);
        repeat (2) begin
            @(posedge clk_i) ext <= 1'b1;
            repeat (6) @(posedge clk_i);
            ext <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
        tick(2);
        rd_reg(TMR3_COUNT_OFS, 16'h0006, "ext pin");
        $display("gate and source done");
        wr_reg(TMR3_CTRL_OFS, 16'h8000);
        tick(1);
        @(posedge clk_i) casc <= 1'b1;
        tick(3);
        @(posedge clk_i) casc <= 1'b0;
        rd_reg(TMR3_COUNT_OFS, 16'h0007, "cascade");
        wr_reg(TMR3_CTRL_OFS, 16'hA000);
        @(posedge clk_i) idle <= 1'b1;
        tick(3);
        rd_reg(TMR3_STAT_OFS, 16'h0002, "halt state");
        chk("running halted", 16'h0000, {15'h0000, run});
        @(posedge clk_i) idle <= 1'b0;
        tick(1);
        rd_reg(TMR3_COUNT_OFS, 16'h0008, "halt resume");
        chk("running on", 16'h0001, {15'h0000, run});
        wr_reg(TMR3_CTRL_OFS, 16'h0000);
        tick(3);
        rd_reg(TMR3_COUNT_OFS, 16'h0008, "run off");
        chk("running off", 16'h0000, {15'h0000, run});
        $display("freeze done");
        close_out();
    end
endmodule
